// file: olfd_display.sv
// Octal two-digit fault code sequencer driving three indicator LEDs
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Failures shown as two octal digits, three LEDs
// - Each digit driven as binary onto LEDs
// - Start marker chases right to left
// - Most significant digit follows the marker
// - Blank pause, then low digit, zero dark
// - Another blank, then whole pattern repeats
// - Self-test codes 04, 15, 16, 17
// - Self-test codes 20 through 23
// - Self-test codes 24 through 27
// - Operational errors carry high digit seven
// - Operational high digit lights all three LEDs
// - Operational low digit, pause, marker, repeat
// - Operational low digits 2 through 7 meanings
module olfd_display #(
  parameter int unsigned MARK_STEP_CYCLES  = olfd_pkg::MARK_STEP_CYC,
  parameter int unsigned DIGIT_SHOW_CYCLES = olfd_pkg::DIGIT_SHOW_CYC,
  parameter int unsigned BLANK_CYCLES      = olfd_pkg::BLANK_CYC
) (
  // Clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_sys_rst,
  // Self-test failure report (same clock)
  input  wire logic                        i_selftest_fail,
  input  wire logic [olfd_pkg::CODE_W-1:0] i_selftest_code,
  // Operational error report (same clock)
  input  wire logic                        i_op_error,
  input  wire logic [olfd_pkg::LED_W-1:0]  i_op_digit,
  // Indicator LEDs, bit 0 rightmost, active high
  output logic      [olfd_pkg::LED_W-1:0]  o_leds,
  // A code is latched and being shown
  output logic                             o_code_active
);
  import olfd_pkg::*;

  // A zero step length would underflow the countdown, refuse it early
  localparam bit STEPS_OK = (MARK_STEP_CYCLES >= 1) &&
                            (DIGIT_SHOW_CYCLES >= 1) && (BLANK_CYCLES >= 1);
  if (!STEPS_OK) begin : g_bad_steps
    $error("olfd_display: step lengths must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    olfd_state_type st;    // Display phase
    logic [31:0]    cnt;   // Cycles left in current step
    logic [1:0]     step;  // Marker position, 0 is rightmost
    logic [5:0]     code;  // Latched code, two octal digits
    logic           held;  // A code has been captured
    logic [2:0]     leds;  // LED drive
  } olfd_reg_type;

  olfd_reg_type r_q;  // Registered state
  olfd_reg_type r_d;  // Next state

  localparam logic [31:0] MARK_LAST  = 32'(MARK_STEP_CYCLES - 1);
  localparam logic [31:0] DIGIT_LAST = 32'(DIGIT_SHOW_CYCLES - 1);
  localparam logic [31:0] BLANK_LAST = 32'(BLANK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    r_d = r_q;
    case (r_q.st)
      // Wait for the first failure; self-test takes priority
      OLFD_IDLE: begin
        r_d.leds = LEDS_OFF;
        if (i_selftest_fail) begin
          r_d.code = i_selftest_code;
          r_d.held = 1'b1;
          r_d.st   = OLFD_MARK;
          r_d.step = 2'h0;
          r_d.cnt  = MARK_LAST;
          r_d.leds = MARK_RIGHT;
        end else if (i_op_error) begin
          r_d.code = {OP_MSD, i_op_digit};
          r_d.held = 1'b1;
          r_d.st   = OLFD_MARK;
          r_d.step = 2'h0;
          r_d.cnt  = MARK_LAST;
          r_d.leds = MARK_RIGHT;
        end
      end
      // Chase one LED from right to left
      OLFD_MARK: begin
        if (r_q.cnt != 32'h0) begin
          r_d.cnt = r_q.cnt - 32'h1;
        end else if (r_q.step != 2'h2) begin
          r_d.step = r_q.step + 2'h1;
          r_d.leds = 3'(MARK_RIGHT << (r_q.step + 2'h1));
          r_d.cnt  = MARK_LAST;
        end else begin
          r_d.st   = OLFD_MSD;
          r_d.leds = r_q.code[MSD_LSB +: LED_W];
          r_d.cnt  = DIGIT_LAST;
        end
      end
      // Show high digit
      OLFD_MSD: begin
        if (r_q.cnt != 32'h0) begin
          r_d.cnt = r_q.cnt - 32'h1;
        end else begin
          r_d.st   = OLFD_GAP1;
          r_d.leds = LEDS_OFF;
          r_d.cnt  = BLANK_LAST;
        end
      end
      // First blank pause
      OLFD_GAP1: begin
        if (r_q.cnt != 32'h0) begin
          r_d.cnt = r_q.cnt - 32'h1;
        end else begin
          r_d.st   = OLFD_LSD;
          r_d.leds = r_q.code[LED_W-1:0];
          r_d.cnt  = DIGIT_LAST;
        end
      end
      // Show low digit; zero leaves LEDs dark
      OLFD_LSD: begin
        if (r_q.cnt != 32'h0) begin
          r_d.cnt = r_q.cnt - 32'h1;
        end else begin
          r_d.st   = OLFD_GAP2;
          r_d.leds = LEDS_OFF;
          r_d.cnt  = BLANK_LAST;
        end
      end
      // Second pause, then restart; new codes never reload
      OLFD_GAP2: begin
        if (r_q.cnt != 32'h0) begin
          r_d.cnt = r_q.cnt - 32'h1;
        end else begin
          r_d.st   = OLFD_MARK;
          r_d.step = 2'h0;
          r_d.leds = MARK_RIGHT;
          r_d.cnt  = MARK_LAST;
        end
      end
      default: begin
        r_d.st   = OLFD_IDLE;
        r_d.leds = LEDS_OFF;
        r_d.cnt  = 32'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_q.st   <= OLFD_IDLE;
      r_q.cnt  <= 32'h0;
      r_q.step <= 2'h0;
      r_q.code <= CODE_RST;
      r_q.held <= 1'b0;
      r_q.leds <= LEDS_OFF;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_leds        = r_q.leds;
  assign o_code_active = r_q.held;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  latch_hold_a: assert property (
    r_q.held |=> (r_q.held && $stable(r_q.code)))
    else $error("latched code changed");

  op_msd_seven_a: assert property (
    (r_q.st == OLFD_IDLE && !i_selftest_fail && i_op_error)
      |=> r_q.code[5:3] == OP_MSD)
    else $error("operational high digit not seven");

  start_right_a: assert property (
    ($past(r_q.st) != OLFD_MARK && r_q.st == OLFD_MARK)
      |-> (r_q.leds == MARK_RIGHT && r_q.step == 2'h0))
    else $error("marker not starting rightmost");

  mark_onehot_a: assert property (
    r_q.st == OLFD_MARK |-> r_q.leds == 3'(MARK_RIGHT << r_q.step))
    else $error("marker led wrong");

  msd_value_a: assert property (
    r_q.st == OLFD_MSD |-> r_q.leds == r_q.code[5:3])
    else $error("high digit wrong");

  lsd_value_a: assert property (
    r_q.st == OLFD_LSD |-> r_q.leds == r_q.code[2:0])
    else $error("low digit wrong");

  gap_dark_a: assert property (
    (r_q.st == OLFD_GAP1 || r_q.st == OLFD_GAP2) |-> r_q.leds == LEDS_OFF)
    else $error("pause not dark");

  repeat_order_a: assert property (
    (r_q.st == OLFD_GAP2 && r_q.cnt == 32'h0) |=> r_q.st == OLFD_MARK)
    else $error("pattern not repeating");

  msd_after_mark_a: assert property (
    (r_q.st == OLFD_MARK && r_q.step == 2'h2 && r_q.cnt == 32'h0)
      |=> r_q.st == OLFD_MSD)
    else $error("high digit not after marker");

  // Each phase must count down from its own step length only
  cnt_bound_a: assert property (
    (r_q.st == OLFD_IDLE && r_q.cnt == 32'h0)
      || (r_q.st == OLFD_MARK && r_q.cnt <= MARK_LAST)
      || ((r_q.st == OLFD_MSD || r_q.st == OLFD_LSD)
          && r_q.cnt <= DIGIT_LAST)
      || ((r_q.st == OLFD_GAP1 || r_q.st == OLFD_GAP2)
          && r_q.cnt <= BLANK_LAST))
    else $error("step counter out of range");

  cv_selftest_c: cover property (r_q.held && r_q.code[5:3] != OP_MSD
                                 && r_q.st == OLFD_LSD);
  cv_operr_c: cover property (r_q.held && r_q.code[5:3] == OP_MSD
                              && r_q.st == OLFD_LSD);
  cv_repeat_c: cover property (r_q.st == OLFD_GAP2 ##1 r_q.st == OLFD_MARK);
  cv_zero_c: cover property (r_q.st == OLFD_LSD && r_q.leds == LEDS_OFF);

endmodule

// file: olfd_pkg.sv
// Package of constants and types for the octal LED fault display
package olfd_pkg;

  // Timing, in milliseconds as chosen for human reading
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned MARK_STEP_MS  = 300;
  localparam int unsigned DIGIT_SHOW_MS = 800;
  localparam int unsigned BLANK_MS      = 500;
  // Derived cycle counts
  localparam int unsigned MARK_STEP_CYC  = CLK_HZ / 1000 * MARK_STEP_MS;
  localparam int unsigned DIGIT_SHOW_CYC = CLK_HZ / 1000 * DIGIT_SHOW_MS;
  localparam int unsigned BLANK_CYC      = CLK_HZ / 1000 * BLANK_MS;

  // LED and code layout
  localparam int unsigned LED_W   = 3;
  localparam int unsigned CODE_W  = 6;
  localparam int unsigned MSD_LSB = 3;
  localparam logic [2:0]  LEDS_OFF = 3'h0;
  localparam logic [2:0]  OP_MSD   = 3'h7;
  localparam logic [2:0]  MARK_RIGHT = 3'h1;
  localparam logic [5:0]  CODE_RST = 6'h00;

  // Self-test codes, hex literal of the two-digit octal value
  localparam logic [5:0] ST_DPRAM      = 6'h04;  // Octal 04
  localparam logic [5:0] ST_GA_PROG    = 6'h0d;  // Octal 15
  localparam logic [5:0] ST_GA_VERIFY  = 6'h0e;  // Octal 16
  localparam logic [5:0] ST_SRAM       = 6'h0f;  // Octal 17
  localparam logic [5:0] ST_HBUF       = 6'h10;  // Octal 20
  localparam logic [5:0] ST_HBUF_PAR   = 6'h11;  // Octal 21
  localparam logic [5:0] ST_DMA_XFER   = 6'h12;  // Octal 22
  localparam logic [5:0] ST_DMA_ADDR   = 6'h13;  // Octal 23
  localparam logic [5:0] ST_CPU_TIMER  = 6'h14;  // Octal 24
  localparam logic [5:0] ST_SCSI_REGS  = 6'h15;  // Octal 25
  localparam logic [5:0] ST_SCSI_HANG  = 6'h16;  // Octal 26
  localparam logic [5:0] ST_UNEXP_IRQ  = 6'h17;  // Octal 27
  // Operational error low digits
  localparam logic [2:0] OP_BAD_IRQ    = 3'h2;
  localparam logic [2:0] OP_REQ_OVF    = 3'h3;
  localparam logic [2:0] OP_DONE_OVF   = 3'h4;
  localparam logic [2:0] OP_CB_OVF     = 3'h5;
  localparam logic [2:0] OP_BAD_CMD    = 3'h6;
  localparam logic [2:0] OP_MEM_FAULT  = 3'h7;

  // Display phases, one-hot
  typedef enum logic [5:0] {
    OLFD_IDLE  = 6'h01,
    OLFD_MARK  = 6'h02,
    OLFD_MSD   = 6'h04,
    OLFD_GAP1  = 6'h08,
    OLFD_LSD   = 6'h10,
    OLFD_GAP2  = 6'h20
  } olfd_state_type;

endpackage

// file: test_olfd_display.sv
// Self-checking bench for the octal LED fault display
`timescale 1ns/1ps
module test_olfd_display;
  import olfd_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Shortened step lengths keep each pattern a few dozen cycles
  localparam int M = 3;
  localparam int D = 5;
  localparam int B = 4;
  localparam int P = 3 * M + 2 * D + 2 * B;
  logic              i_sys_clk;
  logic              i_sys_rst;
  logic              i_selftest_fail;
  logic [CODE_W-1:0] i_selftest_code;
  logic              i_op_error;
  logic [LED_W-1:0]  i_op_digit;
  logic [LED_W-1:0]  o_leds;
  logic              o_code_active;
  int                miscompares = 0;
  int                n_tests = 0;
  logic [31:0]       seed = 32'hc0f59d85;
  logic [5:0]        codes [12] = '{ST_DPRAM, ST_GA_PROG, ST_GA_VERIFY,
    ST_SRAM, ST_HBUF, ST_HBUF_PAR, ST_DMA_XFER, ST_DMA_ADDR, ST_CPU_TIMER,
    ST_SCSI_REGS, ST_SCSI_HANG, ST_UNEXP_IRQ};

  olfd_display #(
    .MARK_STEP_CYCLES  (M),
    .DIGIT_SHOW_CYCLES (D),
    .BLANK_CYCLES      (B)
  ) i_dut (
    .i_sys_clk       (i_sys_clk),
    .i_sys_rst       (i_sys_rst),
    .i_selftest_fail (i_selftest_fail),
    .i_selftest_code (i_selftest_code),
    .i_op_error      (i_op_error),
    .i_op_digit      (i_op_digit),
    .o_leds          (o_leds),
    .o_code_active   (o_code_active)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // Next random word, Galois form
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h00000000);
  endfunction

  // Expected LEDs t cycles after the capturing edge
  function automatic logic [2:0] exp_leds(input logic [5:0] c, input int t);
    int k;
    k = t % P;
    if (k < M) return MARK_RIGHT;
    if (k < 2 * M) return 3'h2;
    if (k < 3 * M) return 3'h4;
    if (k < 3 * M + D) return c[5:3];
    if (k < 3 * M + D + B) return LEDS_OFF;
    if (k < 3 * M + 2 * D + B) return c[2:0];
    return LEDS_OFF;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one per kind of result
  task automatic chk_leds(input string what, input logic [2:0] e,
                          input logic [2:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", what, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Reset for n cycles, outputs must be dark at its end
  task automatic do_reset(input int n);
    @(posedge i_sys_clk);
    i_sys_rst       <= 1'b1;
    i_selftest_fail <= 1'b0;
    i_op_error      <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
    chk_leds("reset leds", LEDS_OFF, o_leds);
    chk_bit("reset active", 1'b0, o_code_active);
    i_sys_rst <= 1'b0;
  endtask

  // One capture, then two full patterns under random later requests
  task automatic show(input logic st, input logic op, input logic [5:0] c,
                      input logic [2:0] d);
    logic [5:0] e;
    e = st ? c : {OP_MSD, d};
    do_reset(2);
    i_selftest_fail <= st;
    i_selftest_code <= c;
    i_op_error      <= op;
    i_op_digit      <= d;
    @(posedge i_sys_clk);
    for (int t = 0; t < 2 * P; t++) begin
      seed = lfsr(seed);
      i_selftest_fail <= seed[0];
      i_op_error      <= seed[1];
      i_selftest_code <= seed[7:2];
      i_op_digit      <= seed[10:8];
      @(negedge i_sys_clk);
      chk_leds("leds", exp_leds(e, t), o_leds);
      chk_bit("active", 1'b1, o_code_active);
      @(posedge i_sys_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    miscompares++;
    end_of_test();
  end

  // Main sequence
  initial begin
    i_sys_rst       = 1'b1;
    i_selftest_fail = 1'b0;
    i_selftest_code = CODE_RST;
    i_op_error      = 1'b0;
    i_op_digit      = 3'h0;
    repeat (8) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    repeat (3) begin
      @(negedge i_sys_clk);
      chk_leds("idle leds", LEDS_OFF, o_leds);
      chk_bit("idle active", 1'b0, o_code_active);
    end
    // Every self-test code, odd ones racing an operational error
    foreach (codes[i]) show(1'b1, i[0], codes[i], 3'(i));
    // Every operational digit, high digit fixed at seven
    for (int d = 2; d < 8; d++) show(1'b0, 1'b1, 6'h00, 3'(d));
    // Corner: low digit zero must leave the LEDs dark (octal 10)
    show(1'b1, 1'b0, 6'h08, 3'h0);
    // Random codes, zero digits included
    repeat (4) begin
      seed = lfsr(seed);
      show(1'b1, 1'b0, seed[5:0], 3'h0);
      show(1'b0, 1'b1, 6'h00, seed[8:6]);
    end
    end_of_test();
  end
endmodule
